// *** src/pidc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module pidc_top #(
  parameter int unsigned CYCLES_PER_MS = pidc_pkg::CYC_PER_MS_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire pidc_pkg::pidc_apb_req_t apb_req,
  output pidc_pkg::pidc_apb_rsp_t apb_rsp,
  input wire logic signed [15:0] target_value,
  input wire logic signed [15:0] feedback_value,
  output pidc_pkg::pidc_cmd_t cmd
);
  import pidc_pkg::*;

  typedef struct packed {
    logic enable;
    pidc_mode_t mode;
    logic tsel;
    logic [15:0] interval;
    logic [15:0] deadband;
    logic [15:0] gain;
    logic [15:0] integral_factor;
    logic [15:0] integral_period;
    logic [15:0] derivative_factor;
    logic [15:0] derivative_period;
    logic signed [15:0] tmin;
    logic signed [15:0] tmax;
    logic signed [15:0] fmin;
    logic signed [15:0] fmax;
    logic signed [15:0] konst;
    logic [15:0] ms_cnt;
    logic [15:0] ivl_cnt;
    pidc_seq_t seq;
    logic signed [15:0] tgt_pct;
    logic signed [15:0] fb_pct;
    logic [31:0] igain;
    logic [31:0] dgain;
    logic signed [17:0] err;
    logic signed [17:0] err_prev;
    logic signed [17:0] delta;
    logic signed [31:0] err_sum;
    logic signed [15:0] out;
    logic out_valid;
    logic [31:0] iter;
    logic [31:0] prdata;
    logic pslverr;
  } pidc_state_t;

  pidc_state_t s;
  pidc_state_t next_s;

  logic div_start;
  logic [DIV_NUM_W-1:0] div_num;
  logic [DIV_DEN_W-1:0] div_den;
  logic div_done;
  logic [DIV_NUM_W-1:0] div_quo;

  logic setup_ph;
  logic access_ph;
  logic tsel_eff;
  logic tick_ms;
  logic due;
  logic [31:0] rd_data;
  logic rd_bad;
  logic [31:0] gain_sat;
  logic signed [17:0] e_raw;
  logic signed [17:0] e_abs;
  logic signed [17:0] e_use;
  logic signed [32:0] sum_wide;
  logic signed [34:0] p_full;
  logic signed [64:0] i_full;
  logic signed [50:0] d_full;
  logic signed [65:0] total;
  logic signed [65:0] lo_lim;
  logic signed [65:0] hi_lim;

  function automatic logic signed [16:0] span_of(input logic signed [15:0] lo, input logic signed [15:0] hi);
    span_of = 17'(hi) - 17'(lo);
  endfunction : span_of

  // Input is clamped into its range first so the numerator never goes negative
  function automatic logic [DIV_NUM_W-1:0] pct_numer(input logic signed [15:0] x, input logic signed [15:0] lo,
                                                      input logic signed [15:0] hi);
    logic signed [16:0] span;
    logic signed [16:0] off;
    span = span_of(lo, hi);
    if (x < lo) begin
      off = 17'sd0;
    end else if (x > hi) begin
      off = span;
    end else begin
      off = 17'(x) - 17'(lo);
    end
    if (span <= 17'sd0) begin
      off = 17'sd0;
    end
    pct_numer = DIV_NUM_W'(off[15:0]) * DIV_NUM_W'(PCT_FULL);
  endfunction : pct_numer

  function automatic logic [DIV_DEN_W-1:0] pct_denom(input logic signed [15:0] lo, input logic signed [15:0] hi);
    logic signed [16:0] span;
    span = span_of(lo, hi);
    pct_denom = (span <= 17'sd0) ? 16'h0001 : span[15:0];
  endfunction : pct_denom

  pidc_div u_div (
    .clk(clk),
    .arst_n(arst_n),
    .start(div_start),
    .dividend(div_num),
    .divisor(div_den),
    .done(div_done),
    .quotient(div_quo)
  );

  always_comb begin
    next_s = s;
    next_s.out_valid = 1'b0;
    div_start = 1'b0;
    div_num = '0;
    div_den = 16'h0001;
    setup_ph = apb_req.psel & ~apb_req.penable;
    access_ph = apb_req.psel & apb_req.penable;
    tsel_eff = s.tsel | (s.mode == MODE_SETPOINT);
    gain_sat = (|div_quo[DIV_NUM_W-1:32]) ? 32'hffffffff : div_quo[31:0];

    // Register read mux, sampled in the setup phase so prdata comes from a flop
    rd_bad = 1'b0;
    rd_data = '0;
    unique case (apb_req.paddr)
      ADDR_CTRL: begin
        rd_data[CTRL_EN_BIT] = s.enable;
        rd_data[CTRL_MODE_LSB +: 2] = s.mode;
        rd_data[CTRL_TSEL_BIT] = tsel_eff;
      end
      ADDR_INTERVAL: rd_data = {16'h0000, s.interval};
      ADDR_DEADBAND: rd_data = {16'h0000, s.deadband};
      ADDR_GAIN: rd_data = {16'h0000, s.gain};
      ADDR_INT_FACTOR: rd_data = {16'h0000, s.integral_factor};
      ADDR_INT_PERIOD: rd_data = {16'h0000, s.integral_period};
      ADDR_DER_FACTOR: rd_data = {16'h0000, s.derivative_factor};
      ADDR_DER_PERIOD: rd_data = {16'h0000, s.derivative_period};
      ADDR_TGT_MIN: rd_data = {16'h0000, s.tmin};
      ADDR_TGT_MAX: rd_data = {16'h0000, s.tmax};
      ADDR_FB_MIN: rd_data = {16'h0000, s.fmin};
      ADDR_FB_MAX: rd_data = {16'h0000, s.fmax};
      ADDR_CONST: rd_data = {16'h0000, s.konst};
      ADDR_OUTPUT: begin
        rd_data[15:0] = s.out;
        rd_data[OUT_BUSY_BIT] = (s.seq != SEQ_IDLE);
        rd_bad = apb_req.pwrite;
      end
      ADDR_ERR_SUM: begin
        rd_data = s.err_sum;
        rd_bad = apb_req.pwrite;
      end
      ADDR_ITER: begin
        rd_data = s.iter;
        rd_bad = apb_req.pwrite;
      end
      default: rd_bad = 1'b1;
    endcase
    if (setup_ph) begin
      next_s.prdata = apb_req.pwrite ? 32'h00000000 : rd_data;
      next_s.pslverr = rd_bad;
    end

    if (access_ph && apb_req.pwrite && !s.pslverr) begin
      unique case (apb_req.paddr)
        ADDR_CTRL: begin
          next_s.enable = apb_req.pwdata[CTRL_EN_BIT];
          next_s.mode = pidc_mode_t'(apb_req.pwdata[CTRL_MODE_LSB +: 2]);
          if (pidc_mode_t'(apb_req.pwdata[CTRL_MODE_LSB +: 2]) == MODE_SETPOINT) begin
            next_s.tsel = 1'b1;
          end else if (s.mode != MODE_SETPOINT) begin
            next_s.tsel = apb_req.pwdata[CTRL_TSEL_BIT];
          end
        end
        ADDR_INTERVAL: next_s.interval = apb_req.pwdata[15:0];
        ADDR_DEADBAND: next_s.deadband = apb_req.pwdata[15:0];
        ADDR_GAIN: next_s.gain = apb_req.pwdata[15:0];
        ADDR_INT_FACTOR: next_s.integral_factor = apb_req.pwdata[15:0];
        ADDR_INT_PERIOD: next_s.integral_period = apb_req.pwdata[15:0];
        ADDR_DER_FACTOR: next_s.derivative_factor = apb_req.pwdata[15:0];
        ADDR_DER_PERIOD: next_s.derivative_period = apb_req.pwdata[15:0];
        ADDR_TGT_MIN: next_s.tmin = apb_req.pwdata[15:0];
        ADDR_TGT_MAX: next_s.tmax = apb_req.pwdata[15:0];
        ADDR_FB_MIN: next_s.fmin = apb_req.pwdata[15:0];
        ADDR_FB_MAX: next_s.fmax = apb_req.pwdata[15:0];
        ADDR_CONST: next_s.konst = apb_req.pwdata[15:0];
        default: ;
      endcase
    end

    // Millisecond enable and interval counter; a zero interval stops the loop
    tick_ms = (s.ms_cnt == 16'(CYCLES_PER_MS - 1));
    due = 1'b0;
    if (!s.enable || s.interval == 16'h0000) begin
      next_s.ms_cnt = '0;
      next_s.ivl_cnt = '0;
    end else begin
      next_s.ms_cnt = tick_ms ? 16'h0000 : s.ms_cnt + 16'h0001;
      if (tick_ms) begin
        if (s.ivl_cnt == s.interval - 16'h0001) begin
          next_s.ivl_cnt = '0;
          due = 1'b1;
        end else begin
          next_s.ivl_cnt = s.ivl_cnt + 16'h0001;
        end
      end
    end

    e_raw = 18'(s.tgt_pct) - 18'(s.fb_pct);
    e_abs = (e_raw < 18'sd0) ? -e_raw : e_raw;
    e_use = (e_abs < $signed({2'b00, s.deadband})) ? 18'sd0 : e_raw;
    sum_wide = 33'(s.err_sum) + 33'(e_use);
    p_full = $signed({1'b0, s.gain}) * s.err;
    i_full = $signed({1'b0, s.igain}) * s.err_sum;
    d_full = $signed({1'b0, s.dgain}) * s.delta;
    total = 66'(p_full >>> GAIN_FRAC) + 66'(i_full >>> KGAIN_FRAC) + 66'(d_full >>> KGAIN_FRAC);
    // Over-target drive rises when feedback exceeds target, so its sense is flipped
    if (s.mode == MODE_OVER) begin
      total = -total;
    end
    hi_lim = 66'(PCT_FULL);
    lo_lim = (s.mode == MODE_SINGLE) ? -66'(PCT_FULL) : 66'(PCT_ZERO);

    unique case (s.seq)
      SEQ_IDLE: begin
        if (due) begin
          div_start = 1'b1;
          if (!tsel_eff) begin
            div_num = pct_numer(target_value, s.tmin, s.tmax);
            div_den = pct_denom(s.tmin, s.tmax);
          end else if (s.mode == MODE_SETPOINT) begin
            div_num = pct_numer(s.konst, s.fmin, s.fmax);
            div_den = pct_denom(s.fmin, s.fmax);
          end else begin
            div_num = pct_numer(s.konst, s.tmin, s.tmax);
            div_den = pct_denom(s.tmin, s.tmax);
          end
          next_s.seq = SEQ_DIV_TGT;
        end
      end
      SEQ_DIV_TGT: begin
        if (div_done) begin
          next_s.tgt_pct = 16'(div_quo);
          div_start = 1'b1;
          div_num = pct_numer(feedback_value, s.fmin, s.fmax);
          div_den = pct_denom(s.fmin, s.fmax);
          next_s.seq = SEQ_DIV_FB;
        end
      end
      SEQ_DIV_FB: begin
        if (div_done) begin
          next_s.fb_pct = 16'(div_quo);
          div_start = 1'b1;
          // T/integral_period with both in milliseconds; the thousandth cancels out
          if (s.integral_period != 16'h0000) begin
            div_num = {32'h0, s.gain} * {32'h0, s.integral_factor} * {32'h0, s.interval};
            div_den = s.integral_period;
          end
          next_s.seq = SEQ_DIV_IG;
        end
      end
      SEQ_DIV_IG: begin
        if (div_done) begin
          next_s.igain = (s.integral_period == 16'h0000) ? 32'h00000000 : gain_sat;
          div_start = 1'b1;
          div_num = {32'h0, s.gain} * {32'h0, s.derivative_factor} * {32'h0, s.derivative_period};
          div_den = s.interval;
          next_s.seq = SEQ_DIV_DG;
        end
      end
      SEQ_DIV_DG: begin
        if (div_done) begin
          next_s.dgain = gain_sat;
          next_s.seq = SEQ_ERR;
        end
      end
      SEQ_ERR: begin
        next_s.err = e_use;
        next_s.delta = e_use - s.err_prev;
        next_s.err_prev = e_use;
        // Sum saturates instead of wrapping, so a long windup cannot flip sign
        if (sum_wide[32] != sum_wide[31]) begin
          next_s.err_sum = sum_wide[32] ? 32'sh80000000 : 32'sh7fffffff;
        end else begin
          next_s.err_sum = sum_wide[31:0];
        end
        next_s.seq = SEQ_SUM;
      end
      SEQ_SUM: begin
        if (total > hi_lim) begin
          next_s.out = PCT_FULL;
        end else if (total < lo_lim) begin
          next_s.out = 16'(lo_lim);
        end else begin
          next_s.out = 16'(total);
        end
        next_s.out_valid = 1'b1;
        next_s.iter = s.iter + 32'h00000001;
        next_s.seq = SEQ_IDLE;
      end
      default: next_s.seq = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.interval <= RST_INTERVAL;
      s.gain <= RST_GAIN;
      s.tmax <= RST_RANGE_MAX;
      s.fmax <= RST_RANGE_MAX;
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp.prdata = s.prdata;
  assign apb_rsp.pslverr = s.pslverr & access_ph;
  assign apb_rsp.pready = access_ph;
  assign cmd.valid = s.out_valid;
  assign cmd.value = s.out;
endmodule : pidc_top
`default_nettype wire

// *** src/pidc_pkg.sv ***
// How it works
// - While enabled, one PID evaluation runs per evaluation_interval_ms milliseconds.
// - Response mode 0 single, 1 setpoint, 2 on over target, 3 on below target.
// - Single mode scales target and feedback each to percent of own range.
// - Single mode output is limited to -100% .. +100%.
// - Setpoint mode forces target source to the constant and locks the selector.
// - Setpoint constant is scaled and bounded by the feedback minimum and maximum.
// - Setpoint mode output is limited to 0% .. 100%.
// - Both push-pull modes limit the output to 0% .. 100%.
// - Error magnitude below error_deadband is replaced by zero.
// - Output is the sum of proportional, integral and derivative terms.
// - Error is target minus feedback; sum adds error to previous sum.
// - Proportional term is overall gain times current error.
// - Integral term is integral gain times current error sum.
// - Derivative term is derivative gain times error change since last iteration.
// - Integral gain is gain*integral_factor*T/integral_period, zero when integral_period is zero.
// - Derivative gain is gain*derivative_factor*derivative_period/T.
// - Sample period T is the interval in milliseconds times one thousandth.
package pidc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INTERVAL = 8'h04;
  localparam logic [7:0] ADDR_DEADBAND = 8'h08;
  localparam logic [7:0] ADDR_GAIN = 8'h0c;
  localparam logic [7:0] ADDR_INT_FACTOR = 8'h10;
  localparam logic [7:0] ADDR_INT_PERIOD = 8'h14;
  localparam logic [7:0] ADDR_DER_FACTOR = 8'h18;
  localparam logic [7:0] ADDR_DER_PERIOD = 8'h1c;
  localparam logic [7:0] ADDR_TGT_MIN = 8'h20;
  localparam logic [7:0] ADDR_TGT_MAX = 8'h24;
  localparam logic [7:0] ADDR_FB_MIN = 8'h28;
  localparam logic [7:0] ADDR_FB_MAX = 8'h2c;
  localparam logic [7:0] ADDR_CONST = 8'h30;
  localparam logic [7:0] ADDR_OUTPUT = 8'h34;
  localparam logic [7:0] ADDR_ERR_SUM = 8'h38;
  localparam logic [7:0] ADDR_ITER = 8'h3c;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_TSEL_BIT = 3;
  localparam int unsigned OUT_BUSY_BIT = 16;

  localparam logic [15:0] RST_INTERVAL = 16'h000a;
  localparam logic [15:0] RST_GAIN = 16'h0100;
  localparam logic signed [15:0] RST_RANGE_MAX = 16'sh2710;

  // Percent values are hundredths of a percent
  localparam logic signed [15:0] PCT_FULL = 16'sh2710;
  localparam logic signed [15:0] PCT_ZERO = 16'sh0000;
  localparam int unsigned GAIN_FRAC = 8;
  localparam int unsigned KGAIN_FRAC = 16;
  localparam int unsigned DIV_NUM_W = 48;
  localparam int unsigned DIV_DEN_W = 16;
  localparam int unsigned DIV_CNT_W = 6;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_SETPOINT,
    MODE_OVER,
    MODE_BELOW
  } pidc_mode_t;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_DIV_TGT,
    SEQ_DIV_FB,
    SEQ_DIV_IG,
    SEQ_DIV_DG,
    SEQ_ERR,
    SEQ_SUM
  } pidc_seq_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pidc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pidc_apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic signed [15:0] value;
  } pidc_cmd_t;
endpackage : pidc_pkg

// *** src/pidc_div.sv ***
`timescale 1ns/100ps
`default_nettype none
module pidc_div (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [pidc_pkg::DIV_NUM_W-1:0] dividend,
  input wire logic [pidc_pkg::DIV_DEN_W-1:0] divisor,
  output logic done,
  output logic [pidc_pkg::DIV_NUM_W-1:0] quotient
);
  import pidc_pkg::*;

  typedef struct packed {
    logic busy;
    logic done;
    logic [DIV_CNT_W-1:0] cnt;
    logic [DIV_DEN_W:0] rem;
    logic [DIV_NUM_W-1:0] quo;
    logic [DIV_DEN_W-1:0] den;
  } pidc_div_state_t;

  pidc_div_state_t s;
  pidc_div_state_t next_s;
  logic [DIV_DEN_W:0] rem_sh;

  // Restoring divider, one quotient bit per cycle; zero divisor gives all ones
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    rem_sh = {s.rem[DIV_DEN_W-1:0], s.quo[DIV_NUM_W-1]};
    if (s.busy) begin
      if (rem_sh >= {1'b0, s.den}) begin
        next_s.rem = rem_sh - {1'b0, s.den};
        next_s.quo = {s.quo[DIV_NUM_W-2:0], 1'b1};
      end else begin
        next_s.rem = rem_sh;
        next_s.quo = {s.quo[DIV_NUM_W-2:0], 1'b0};
      end
      next_s.cnt = s.cnt - 1'b1;
      if (s.cnt == '0) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end else if (start) begin
      next_s.busy = 1'b1;
      next_s.cnt = DIV_CNT_W'(DIV_NUM_W - 1);
      next_s.rem = '0;
      next_s.quo = dividend;
      next_s.den = divisor;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign quotient = s.quo;
endmodule : pidc_div
`default_nettype wire

// *** test/pidc_drive_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pidc_drive_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire pidc_pkg::pidc_cmd_t cmd,
  output logic signed [15:0] duty,
  output int unsigned n_rx
);
  import pidc_pkg::*;
  // Both push-pull halves take this one command, so they share target and feedback
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      duty <= '0;
      n_rx <= 0;
    end else if (cmd.valid) begin
      duty <= cmd.value;
      n_rx <= n_rx + 1;
    end
  end
endmodule : pidc_drive_model
`default_nettype wire

// *** test/pidc_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module pidc_monitor #(
  parameter int unsigned CYCLES_PER_MS = 10
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire pidc_pkg::pidc_apb_req_t apb_req,
  input wire pidc_pkg::pidc_apb_rsp_t apb_rsp,
  input wire logic signed [15:0] target_value,
  input wire logic signed [15:0] feedback_value,
  input wire pidc_pkg::pidc_cmd_t cmd
);
  import pidc_pkg::*;
  logic [1:0] mode_q;
  logic en_q;
  logic seen_q;
  logic [15:0] ivl_q;
  int unsigned cnt_q;
  logic wr_go;
  logic rd_go;
  assign wr_go = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_go = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  // Any write voids the spacing check, since config may have moved
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 2'h0;
      en_q <= 1'b0;
      seen_q <= 1'b0;
      ivl_q <= 16'h000a;
      cnt_q <= 0;
    end else begin
      cnt_q <= cmd.valid ? 1 : cnt_q + 1;
      if (wr_go) begin
        seen_q <= 1'b0;
        if (apb_req.paddr == ADDR_CTRL) begin
          en_q <= apb_req.pwdata[0];
          mode_q <= apb_req.pwdata[2:1];
        end
        if (apb_req.paddr == ADDR_INTERVAL) begin
          ivl_q <= apb_req.pwdata[15:0];
        end
      end else if (cmd.valid) begin
        seen_q <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  valid_pulse_a: assert property (cmd.valid |=> !cmd.valid [*8])
    else $error("command strobe too long");
  period_exact_a: assert property (cmd.valid && seen_q |-> cnt_q == ivl_q * CYCLES_PER_MS)
    else $error("iteration spacing wrong");
  enabled_only_a: assert property (cmd.valid |-> en_q)
    else $error("command while disabled");
  hold_value_a: assert property ($changed(cmd.value) |-> cmd.valid)
    else $error("command value moved without strobe");
  single_span_a: assert property (cmd.valid && mode_q == 2'd0 |-> cmd.value >= -16'sd10000
    && cmd.value <= 16'sd10000) else $error("single mode out of span");
  setpoint_span_a: assert property (cmd.valid && mode_q == 2'd1 |-> cmd.value >= 16'sd0
    && cmd.value <= 16'sd10000) else $error("setpoint mode out of span");
  push_span_a: assert property (cmd.valid && mode_q[1] |-> cmd.value >= 16'sd0
    && cmd.value <= 16'sd10000) else $error("push-pull out of span");
  target_lock_a: assert property (rd_go && apb_req.paddr == ADDR_CTRL && mode_q == 2'd1 |-> apb_rsp.prdata[3])
    else $error("target select not locked");
  ready_now_a: assert property (apb_req.psel && !apb_req.penable ##1 apb_req.penable |-> apb_rsp.pready)
    else $error("no ready in access phase");
  ro_refuse_a: assert property (wr_go && apb_req.paddr inside {8'h34, 8'h38, 8'h3c} |-> apb_rsp.pslverr)
    else $error("read-only write accepted");
  cover property (cmd.valid && mode_q == 2'd0);
  cover property (cmd.valid && mode_q == 2'd1);
  cover property (cmd.valid && mode_q[1]);
  cover property (wr_go && apb_rsp.pslverr);
endmodule : pidc_monitor
bind pidc_top pidc_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) pidc_monitor_i (.clk(clk), .arst_n(arst_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .target_value(target_value), .feedback_value(feedback_value), .cmd(cmd));
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pidc_pkg::*;
  localparam int unsigned CPM = 10;
  localparam logic [7:0] CFG_AD [12] = '{ADDR_INTERVAL, ADDR_DEADBAND, ADDR_GAIN, ADDR_INT_FACTOR, ADDR_INT_PERIOD,
    ADDR_DER_FACTOR, ADDR_DER_PERIOD, ADDR_TGT_MIN, ADDR_TGT_MAX, ADDR_FB_MIN, ADDR_FB_MAX, ADDR_CONST};
  logic clk;
  logic arst_n;
  pidc_apb_req_t req;
  pidc_apb_rsp_t rsp;
  logic signed [15:0] tv;
  logic signed [15:0] fv;
  pidc_cmd_t cmd;
  logic signed [15:0] duty;
  int unsigned n_rx;
  int bad_count;
  int n_checks;
  logic signed [15:0] exp_q[$];
  logic signed [15:0] last_v;
  logic [31:0] r;
  logic e;
  logic tsel;
  longint g, int_fac, int_per, der_fac, der_per, ivl, db, tmin, tmax, fmin, fmax, cst, tt, ff, sum, ep;
  int mode;

  pidc_top #(.CYCLES_PER_MS(CPM)) pidc_top_i (.clk(clk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
    .target_value(tv), .feedback_value(fv), .cmd(cmd));
  pidc_drive_model pidc_drive_model_i (.clk(clk), .arst_n(arst_n), .cmd(cmd), .duty(duty), .n_rx(n_rx));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
    n_checks++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h want %h", $time, m, got, want);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    if (rsp.pready !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED t=%0t no ready", $time);
    end
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(32'(e), 32'h0, "write refused");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] want, input string m);
    apb(1'b0, a, 32'h0);
    chk(r, want, m);
  endtask : rd

  function automatic longint pct(longint x, longint lo, longint hi);
    if (hi <= lo) return 0;
    if (x < lo) x = lo;
    if (x > hi) x = hi;
    return (x - lo) * 10000 / (hi - lo);
  endfunction : pct

  task automatic predict;
    longint tp, er, o, lo;
    tp = (mode == 1) ? pct(cst, fmin, fmax) : pct(tsel ? cst : tt, tmin, tmax);
    er = tp - pct(ff, fmin, fmax);
    if (er < db && -er < db) er = 0;
    sum = sum + er;
    o = ((g * er) >>> 8) + (((int_per == 0 ? 0 : g * int_fac * ivl / int_per) * sum) >>> 16)
      + (((g * der_fac * der_per / ivl) * (er - ep)) >>> 16);
    ep = er;
    if (mode == 2) o = -o;
    lo = (mode == 0) ? -10000 : 0;
    o = (o > 10000) ? 10000 : (o < lo ? lo : o);
    last_v = 16'(o);
    exp_q.push_back(16'(o));
  endtask : predict

  task automatic set_in(input longint t, input longint f);
    tt = t;
    ff = f;
    @(posedge clk);
    tv <= 16'(t);
    fv <= 16'(f);
  endtask : set_in

  task automatic run(input int n, input string name);
    longint v [12];
    int unsigned base;
    longint k;
    // Second write lands the select bit once the mode that locks it is gone
    wr(ADDR_CTRL, {28'h0, tsel, 2'(mode), 1'b0});
    wr(ADDR_CTRL, {28'h0, tsel, 2'(mode), 1'b0});
    v = '{ivl, db, g, int_fac, int_per, der_fac, der_per, tmin, tmax, fmin, fmax, cst};
    for (int i = 0; i < 12; i++) wr(CFG_AD[i], {16'h0, 16'(v[i])});
    for (int i = 0; i < n; i++) predict();
    base = n_rx;
    wr(ADDR_CTRL, {28'h0, tsel, 2'(mode), 1'b1});
    k = 0;
    while (n_rx < base + n && k < (n + 2) * ivl * CPM) begin
      @(posedge clk);
      k++;
    end
    wr(ADDR_CTRL, {28'h0, tsel, 2'(mode), 1'b0});
    rd(ADDR_ERR_SUM, 32'(sum), "error sum");
    chk(32'(duty), 32'(last_v), "drive level");
    chk(32'(exp_q.size()), 32'h0, "missing results");
    $display("test %s done", name);
  endtask : run

  always @(posedge clk) begin
    if (cmd.valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0, "unexpected result");
      else chk(32'(cmd.value), 32'(exp_q.pop_front()), "command");
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    req = '0;
    tv = '0;
    fv = '0;
    arst_n = 1'b0;
    bad_count = 0;
    n_checks = 0;
    sum = 0;
    ep = 0;
    mode = 0;
    tsel = 1'b0;
    g = 256;
    int_fac = 256;
    int_per = 30;
    der_fac = 256;
    der_per = 30;
    ivl = 30;
    db = 0;
    tmin = 0;
    tmax = 10000;
    fmin = 0;
    fmax = 10000;
    cst = 0;
    void'($urandom(38507));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(ADDR_CTRL, 32'h0, "ctrl reset");
    rd(ADDR_INTERVAL, 32'h000a, "interval reset");
    rd(ADDR_GAIN, 32'h0100, "gain reset");
    rd(ADDR_FB_MAX, 32'h2710, "range reset");
    rd(ADDR_ERR_SUM, 32'h0, "sum reset");
    rd(ADDR_OUTPUT, 32'h0, "output reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(e), 32'h1, "unmapped");
    apb(1'b1, ADDR_OUTPUT, 32'h5);
    chk(32'(e), 32'h1, "read-only");
    $display("test registers done");
    set_in($urandom_range(10000), $urandom_range(10000));
    run(3, "single");
    tmax = 20000;
    set_in($urandom_range(20000), $urandom_range(10000));
    run(2, "scaling");
    tmax = 10000;
    db = 500;
    set_in(5000, 5499);
    run(2, "deadband");
    set_in(5000, 5500);
    run(1, "deadband edge");
    db = 0;
    int_per = 0;
    int_fac = 4096;
    run(2, "no integral");
    int_per = 60;
    int_fac = 256;
    ivl = 40;
    run(2, "period");
    ivl = 30;
    g = 4096;
    int_fac = 0;
    der_fac = 0;
    set_in(10000, 0);
    run(1, "clamp high");
    set_in(0, 10000);
    run(1, "clamp low");
    // Target port at zero would clamp low, the constant clamps high
    tsel = 1'b1;
    cst = 7000;
    set_in(0, 5000);
    run(1, "constant target");
    tsel = 1'b0;
    mode = 1;
    g = 1024;
    fmin = 2000;
    cst = 12000;
    set_in($urandom_range(10000), 6000);
    run(2, "setpoint");
    rd(ADDR_CTRL, 32'h0000000a, "target locked");
    cst = 4000;
    set_in(0, 10000);
    run(1, "setpoint low");
    rd(ADDR_ITER, 32'h00000012, "iterations");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    sum = 0;
    ep = 0;
    rd(ADDR_ERR_SUM, 32'h0, "sum after reset");
    rd(ADDR_ITER, 32'h0, "iterations after reset");
    rd(ADDR_OUTPUT, 32'h0, "output after reset");
    $display("test mid reset done");
    fmin = 0;
    int_fac = 256;
    der_fac = 256;
    for (int m = 0; m < 4; m++) begin
      mode = m;
      set_in($urandom_range(10000), $urandom_range(10000));
      run(2, "mode");
    end
    finish_test();
  end
endmodule : testbench
`default_nettype wire
